//--- ests_pkg.sv
// Function
// - register-indirect call pushes PC+2, loads PC from accumulator and latches, then idles.
// - indexed-to-file move: first word holds 7-bit offset added to frame pointer.
// - indexed-to-file move destination is the 12-bit field of the second word.
// - computed source and destination addresses may fall anywhere in 000h..FFFh.
// - moves never target PC low byte or top-of-stack bytes; software avoids them.
// - indexed-to-indexed move: both addresses are frame pointer plus 7-bit offsets.
// - indexed source hitting an indirect register yields 00h, no indirect access.
// - indexed destination hitting an indirect register suppresses the write entirely.
// - literal push writes literal at frame pointer then decrements it, one cycle.
// - pointer subtract takes a 6-bit literal from pointer 0..2 in one cycle.
// - pointer select 3 subtracts from frame pointer then returns from top of stack.
// - subtract-and-return takes two cycles, the second one idle.
// - enabling the extension enables offset addressing; disabled, new opcodes do nothing.
// - extension off: access bit 0 selects access bank, 1 selects bank register.
// - extension on, access bit 0, operand up to 5Fh is a frame-pointer offset.
// - with frame pointer zero, offset operands map to legacy access-bank locations.
// - destination bit of byte instructions keeps its meaning in offset mode.
// - enable bit resets to 0, both features off until set to 1.
`default_nettype none

package ests_pkg;
   // ****************************************
   // instruction cycle phases
   // ****************************************
   localparam logic [1:0] PH_DECODE = 2'h0;
   localparam logic [1:0] PH_READ = 2'h1;
   localparam logic [1:0] PH_PROC = 2'h2;
   localparam logic [1:0] PH_WRITE = 2'h3;

   // ****************************************
   // opcodes and fields
   // ****************************************
   localparam logic [15:0] OP_CALL_ACC = 16'h0014;
   localparam logic [8:0] OP_MOVE_FILE = 9'h1D6;
   localparam logic [8:0] OP_MOVE_IDX = 9'h1D7;
   localparam logic [7:0] OP_PUSH_LIT = 8'hFA;
   localparam logic [7:0] OP_PTR_SUB = 8'hE9;
   localparam logic [1:0] SEL_FRAME_RET = 2'h3;
   localparam int FSEL_HI = 7;
   localparam int FSEL_LO = 6;
   localparam int ACCESS_BIT = 8;
   localparam int DEST_BIT = 9;
   localparam logic [7:0] OFFSET_MAX = 8'h5F;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [20:0] RET_STEP = 21'h000002;
   localparam logic [11:0] PUSH_STEP = 12'h001;
   localparam logic [7:0] SRC_INDIRECT_VALUE = 8'h00;

   // ****************************************
   // indirect access window
   // ****************************************
   localparam logic [11:0] IND_LO = 12'hFDB;
   localparam logic [11:0] IND_HI = 12'hFEF;

   // ****************************************
   // register port map and reset values
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_PTR_BASE = 8'h04;
   localparam logic [7:0] REG_STEP = 8'h04;
   localparam logic [7:0] REG_STATE = 8'h10;
   localparam int CTRL_EXT_BIT = 0;
   localparam logic CTRL_EXT_RESET = 1'b0;
   localparam logic [11:0] PTR_RESET = 12'h000;
   localparam int NUM_PTR = 3;
   localparam int FRAME = 2;

   typedef enum logic [2:0] {
      ST_FIRST = 3'h1,
      ST_MOVE2 = 3'h2,
      ST_NOP = 3'h4
   } ests_state_e;

   function automatic logic is_indirect(input logic [11:0] a);
      return (a >= IND_LO) && (a <= IND_HI);
   endfunction : is_indirect
endpackage : ests_pkg

// ****************************************
// operand address former
// ****************************************
module ests_addr (
   // operand fields
   input wire logic [7:0] file_field,
   input wire logic access_sel,
   // context
   input wire logic ext_en,
   input wire logic [11:0] frame_ptr,
   input wire logic [3:0] bank_select,
   // result
   output logic [11:0] addr
);
   always_comb begin
      if (access_sel) begin
         addr = {bank_select, file_field};
      end else if (ext_en && (file_field <= ests_pkg::OFFSET_MAX)) begin
         addr = frame_ptr + {4'h0, file_field};
      end else if (file_field <= ests_pkg::OFFSET_MAX) begin
         addr = {ests_pkg::ACCESS_LOW_BANK, file_field};
      end else begin
         addr = {ests_pkg::ACCESS_HIGH_BANK, file_field};
      end
   end
endmodule : ests_addr

`default_nettype wire

//--- ests_core.sv
// Design decisions made here: the strobed register port and the register addresses.
`default_nettype none

module ests_core (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // instruction stream and core context
   input wire logic [15:0] instr,
   input wire logic [20:0] pc,
   input wire logic [7:0] acc,
   input wire logic [3:0] bank_select,
   input wire logic [7:0] pc_high_latch,
   input wire logic [4:0] pc_upper_latch,
   input wire logic [20:0] stack_top,
   output logic cycle_start,
   output logic ext_active,
   output logic [11:0] std_addr,
   output logic std_dest_to_acc,
   // data memory
   output logic [11:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   // return stack and program counter
   output logic stack_push,
   output logic [20:0] stack_push_data,
   output logic stack_pop,
   output logic pc_load,
   output logic [20:0] pc_load_value
);
   // ****************************************
   // reset release
   // ****************************************
   logic rst_meta_n;
   logic rst_sync_n;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // ****************************************
   // state and decode
   // ****************************************
   logic [1:0] q, next_q;
   ests_pkg::ests_state_e state, next_state;
   logic [15:0] instr_q, next_instr_q;
   logic ext_en, next_ext_en;
   logic [11:0] file_select_pointer [ests_pkg::NUM_PTR];
   logic [11:0] next_fsr [ests_pkg::NUM_PTR];
   logic [7:0] moved, next_moved;
   logic move_ss, next_move_ss;
   logic next_cycle_start, next_ext_active, next_std_dest_to_acc;
   logic [11:0] next_std_addr, next_mem_addr;
   logic next_mem_rd, next_mem_wr, next_stack_push, next_stack_pop;
   logic next_pc_load;
   logic [7:0] next_mem_wdata;
   logic [20:0] next_stack_push_data, next_pc_load_value;
   logic [15:0] next_reg_rdata;
   logic [11:0] remap_addr, src_addr, dst_addr;
   logic dec_indexed_to_file_move, dec_indexed_to_indexed_move, dec_literal_push, dec_pointer_subtract_literal, dec_accumulator_indirect_call;
   logic [1:0] dec_fsel;
   logic first_ext;

   assign dec_indexed_to_file_move = instr_q[15:7] == ests_pkg::OP_MOVE_FILE;
   assign dec_indexed_to_indexed_move = instr_q[15:7] == ests_pkg::OP_MOVE_IDX;
   assign dec_literal_push = instr_q[15:8] == ests_pkg::OP_PUSH_LIT;
   assign dec_pointer_subtract_literal = instr_q[15:8] == ests_pkg::OP_PTR_SUB;
   assign dec_accumulator_indirect_call = instr_q == ests_pkg::OP_CALL_ACC;
   assign dec_fsel = instr_q[ests_pkg::FSEL_HI:ests_pkg::FSEL_LO];
   assign first_ext = ext_en && (state == ests_pkg::ST_FIRST) &&
      (dec_indexed_to_file_move || dec_indexed_to_indexed_move || dec_literal_push || dec_pointer_subtract_literal || dec_accumulator_indirect_call);
   assign src_addr = file_select_pointer[ests_pkg::FRAME] + {5'h00, instr_q[6:0]};
   assign dst_addr = move_ss ? file_select_pointer[ests_pkg::FRAME] + {5'h00, instr_q[6:0]}
                             : instr_q[11:0];

   ests_addr u_addr (
      .file_field(instr_q[7:0]),
      .access_sel(instr_q[ests_pkg::ACCESS_BIT]),
      .ext_en(ext_en),
      .frame_ptr(file_select_pointer[ests_pkg::FRAME]),
      .bank_select(bank_select),
      .addr(remap_addr)
   );

   function automatic logic [15:0] read_mux(input logic [7:0] a,
         input logic en, input logic [11:0] p0, input logic [11:0] p1,
         input logic [11:0] p2, input logic [5:0] st);
      logic [15:0] r;
      r = 16'h0000;
      case (a)
         ests_pkg::REG_CTRL: r = {15'h0000, en};
         ests_pkg::REG_PTR_BASE: r = {4'h0, p0};
         ests_pkg::REG_PTR_BASE + ests_pkg::REG_STEP: r = {4'h0, p1};
         ests_pkg::REG_PTR_BASE + 8'h08: r = {4'h0, p2};
         ests_pkg::REG_STATE: r = {10'h000, st};
         default: r = 16'h0000;
      endcase
      return r;
   endfunction : read_mux

   // ****************************************
   // next-state logic
   // ****************************************
   always_comb begin
      next_q = q + 2'h1;
      next_state = state;
      next_instr_q = instr_q;
      next_ext_en = ext_en;
      next_fsr = file_select_pointer;
      next_moved = moved;
      next_move_ss = move_ss;
      next_cycle_start = (q == ests_pkg::PH_WRITE);
      next_ext_active = ext_active;
      next_std_addr = std_addr;
      next_std_dest_to_acc = std_dest_to_acc;
      next_mem_addr = mem_addr;
      next_mem_rd = 1'b0;
      next_mem_wr = 1'b0;
      next_mem_wdata = mem_wdata;
      next_stack_push = 1'b0;
      next_stack_push_data = stack_push_data;
      next_stack_pop = 1'b0;
      next_pc_load = 1'b0;
      next_pc_load_value = pc_load_value;
      next_reg_rdata = 16'h0000;
      if (reg_rd) begin
         next_reg_rdata = read_mux(reg_addr, ext_en, file_select_pointer[0], file_select_pointer[1], file_select_pointer[2],
            {ext_active, state, q});
      end
      // bus writes first, instruction updates below take precedence
      if (reg_wr) begin
         if (reg_addr == ests_pkg::REG_CTRL) begin
            next_ext_en = reg_wdata[ests_pkg::CTRL_EXT_BIT];
         end
         for (int i = 0; i < ests_pkg::NUM_PTR; i++) begin
            if (reg_addr == ests_pkg::REG_PTR_BASE + 8'(i * 4)) begin
               next_fsr[i] = reg_wdata[11:0];
            end
         end
      end
      if (q == ests_pkg::PH_DECODE) begin
         next_instr_q = instr;
      end
      case (state)
         ests_pkg::ST_FIRST: begin
            if (q == ests_pkg::PH_READ) begin
               next_ext_active = first_ext;
               next_std_addr = remap_addr;
               next_std_dest_to_acc = ~instr_q[ests_pkg::DEST_BIT];
               if (first_ext && (dec_indexed_to_file_move || dec_indexed_to_indexed_move)) begin
                  next_mem_addr = src_addr;
                  next_mem_rd = ~ests_pkg::is_indirect(src_addr);
               end
            end
            if ((q == ests_pkg::PH_PROC) && ext_en && dec_accumulator_indirect_call) begin
               next_stack_push = 1'b1;
               next_stack_push_data = pc + ests_pkg::RET_STEP;
            end
            if ((q == ests_pkg::PH_WRITE) && ext_en) begin
               if (dec_indexed_to_file_move || dec_indexed_to_indexed_move) begin
                  next_moved = ests_pkg::is_indirect(src_addr) ?
                     ests_pkg::SRC_INDIRECT_VALUE : mem_rdata;
                  next_move_ss = dec_indexed_to_indexed_move;
                  next_state = ests_pkg::ST_MOVE2;
               end else if (dec_literal_push) begin
                  next_mem_addr = file_select_pointer[ests_pkg::FRAME];
                  next_mem_wdata = instr_q[7:0];
                  next_mem_wr = 1'b1;
                  next_fsr[ests_pkg::FRAME] =
                     file_select_pointer[ests_pkg::FRAME] - ests_pkg::PUSH_STEP;
               end else if (dec_pointer_subtract_literal) begin
                  if (dec_fsel == ests_pkg::SEL_FRAME_RET) begin
                     next_fsr[ests_pkg::FRAME] =
                        file_select_pointer[ests_pkg::FRAME] - {6'h00, instr_q[5:0]};
                     next_stack_pop = 1'b1;
                     next_pc_load = 1'b1;
                     next_pc_load_value = stack_top;
                     next_state = ests_pkg::ST_NOP;
                  end else begin
                     next_fsr[dec_fsel] = file_select_pointer[dec_fsel] - {6'h00, instr_q[5:0]};
                  end
               end else if (dec_accumulator_indirect_call) begin
                  next_pc_load = 1'b1;
                  next_pc_load_value = {pc_upper_latch, pc_high_latch, acc};
                  next_state = ests_pkg::ST_NOP;
               end
            end
         end
         ests_pkg::ST_MOVE2: begin
            if (q == ests_pkg::PH_READ) begin
               next_ext_active = 1'b1;
               next_mem_addr = dst_addr;
            end
            if (q == ests_pkg::PH_WRITE) begin
               next_mem_wr = ~(move_ss && ests_pkg::is_indirect(dst_addr));
               next_mem_wdata = moved;
               next_state = ests_pkg::ST_FIRST;
            end
         end
         ests_pkg::ST_NOP: begin
            if (q == ests_pkg::PH_READ) begin
               next_ext_active = 1'b1;
            end
            if (q == ests_pkg::PH_WRITE) begin
               next_state = ests_pkg::ST_FIRST;
            end
         end
         default: begin
            next_state = ests_pkg::ST_FIRST;
         end
      endcase
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         q <= ests_pkg::PH_DECODE;
         state <= ests_pkg::ST_FIRST;
         instr_q <= 16'h0000;
         ext_en <= ests_pkg::CTRL_EXT_RESET;
         for (int i = 0; i < ests_pkg::NUM_PTR; i++) begin
            file_select_pointer[i] <= ests_pkg::PTR_RESET;
         end
         moved <= 8'h00;
         move_ss <= 1'b0;
         cycle_start <= 1'b0;
         ext_active <= 1'b0;
         std_addr <= 12'h000;
         std_dest_to_acc <= 1'b0;
         mem_addr <= 12'h000;
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_wdata <= 8'h00;
         stack_push <= 1'b0;
         stack_push_data <= 21'h000000;
         stack_pop <= 1'b0;
         pc_load <= 1'b0;
         pc_load_value <= 21'h000000;
         reg_rdata <= 16'h0000;
      end else begin
         q <= next_q;
         state <= next_state;
         instr_q <= next_instr_q;
         ext_en <= next_ext_en;
         file_select_pointer <= next_fsr;
         moved <= next_moved;
         move_ss <= next_move_ss;
         cycle_start <= next_cycle_start;
         ext_active <= next_ext_active;
         std_addr <= next_std_addr;
         std_dest_to_acc <= next_std_dest_to_acc;
         mem_addr <= next_mem_addr;
         mem_rd <= next_mem_rd;
         mem_wr <= next_mem_wr;
         mem_wdata <= next_mem_wdata;
         stack_push <= next_stack_push;
         stack_push_data <= next_stack_push_data;
         stack_pop <= next_stack_pop;
         pc_load <= next_pc_load;
         pc_load_value <= next_pc_load_value;
         reg_rdata <= next_reg_rdata;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_n);

   logic at_first;
   assign at_first = (state == ests_pkg::ST_FIRST) && ext_en;

   a_push_store: assert property (
      (at_first && q == ests_pkg::PH_WRITE && dec_literal_push && !reg_wr) |=>
      (mem_wr && mem_addr == $past(file_select_pointer[2]) && mem_wdata == $past(instr_q[7:0])
       && file_select_pointer[2] == $past(file_select_pointer[2]) - 12'h001))
      else $error("literal push store or decrement wrong");
   a_ptr_sub: assert property (
      (at_first && q == ests_pkg::PH_WRITE && dec_pointer_subtract_literal && dec_fsel == 2'h0
       && !reg_wr) |=> file_select_pointer[0] == $past(file_select_pointer[0]) - {6'h00, $past(instr_q[5:0])})
      else $error("pointer subtract wrong");
   a_ret_load: assert property (
      (at_first && q == ests_pkg::PH_WRITE && dec_pointer_subtract_literal && dec_fsel == 2'h3)
      |=> (pc_load && stack_pop && pc_load_value == $past(stack_top)))
      else $error("subtract-and-return did not return");
   a_ret_idle: assert property (
      (at_first && q == ests_pkg::PH_WRITE && dec_pointer_subtract_literal && dec_fsel == 2'h3)
      |=> (state == ests_pkg::ST_NOP)[*4] ##1 (state == ests_pkg::ST_FIRST))
      else $error("return second cycle not idle");
   a_call_push: assert property (
      (at_first && q == ests_pkg::PH_PROC && dec_accumulator_indirect_call) |=>
      (stack_push && stack_push_data == $past(pc) + 21'h000002) ##1
      (pc_load && pc_load_value == $past({pc_upper_latch, pc_high_latch, acc})))
      else $error("accumulator call wrong");
   a_src_zero: assert property (
      (at_first && q == ests_pkg::PH_READ && (dec_indexed_to_file_move || dec_indexed_to_indexed_move)
       && ests_pkg::is_indirect(src_addr)) |=> !mem_rd ##2 (moved == 8'h00))
      else $error("indirect source not zero");
   a_dest_skip: assert property (
      (state == ests_pkg::ST_MOVE2 && q == ests_pkg::PH_WRITE && move_ss
       && ests_pkg::is_indirect(dst_addr)) |=> !mem_wr)
      else $error("indirect destination written");
   a_file_dest: assert property (
      (state == ests_pkg::ST_MOVE2 && q == ests_pkg::PH_WRITE && !move_ss)
      |=> (mem_wr && mem_addr == $past(instr_q[11:0])))
      else $error("file destination wrong");
   a_move_span: assert property (
      (at_first && q == ests_pkg::PH_READ && dec_indexed_to_file_move
       && !ests_pkg::is_indirect(src_addr)) |=> mem_rd ##6 mem_wr)
      else $error("move timing wrong");
   a_legacy_map: assert property (
      (at_first && q == ests_pkg::PH_READ && file_select_pointer[2] == 12'h000
       && !instr_q[8] && instr_q[7:0] <= 8'h5F)
      |=> std_addr == {4'h0, $past(instr_q[7:0])})
      else $error("zero frame pointer not legacy");
   a_ext_gate: assert property (
      (!ext_en && state == ests_pkg::ST_FIRST && q == ests_pkg::PH_WRITE)
      |=> (!mem_wr && !pc_load && !stack_pop))
      else $error("extension off but acted");

   c_push: cover property (at_first && q == ests_pkg::PH_WRITE && dec_literal_push);
   c_ret: cover property (pc_load && stack_pop);
   c_move_ss: cover property (state == ests_pkg::ST_MOVE2 && move_ss ##4 mem_wr);
endmodule : ests_core

`default_nettype wire

//--- tb_extended_stack_instruction_exec.sv
`default_nettype none

module tb_extended_stack_instruction_exec;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] instr = 16'h0000;
   logic [20:0] pc = 21'h000000;
   logic [7:0] acc = 8'h00;
   logic [3:0] bank_select = 4'h0;
   logic [7:0] pc_high_latch = 8'h00;
   logic [4:0] pc_upper_latch = 5'h00;
   logic [20:0] stack_top = 21'h000000;
   logic [7:0] mem_rdata = 8'h00;
   logic [15:0] reg_rdata;
   logic cycle_start, ext_active, std_dest_to_acc, mem_rd, mem_wr;
   logic stack_push, stack_pop, pc_load;
   logic [11:0] std_addr, mem_addr;
   logic [7:0] mem_wdata;
   logic [20:0] stack_push_data, pc_load_value;
   logic [31:0] seed = 32'h0000B7C9;
   logic [31:0] rd_q[$], wr_q[$], push_q[$], load_q[$];
   logic [31:0] erd[$], ewr[$], epush[$], eload[$];
   int pops = 0;
   int epops = 0;
   int failures = 0;
   int samples_checked = 0;
   logic [11:0] fp_m[3] = '{12'h000, 12'h000, 12'h000};

   ests_core i_ests_core (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .instr(instr), .pc(pc), .acc(acc),
      .bank_select(bank_select), .pc_high_latch(pc_high_latch),
      .pc_upper_latch(pc_upper_latch), .stack_top(stack_top),
      .cycle_start(cycle_start), .ext_active(ext_active),
      .std_addr(std_addr), .std_dest_to_acc(std_dest_to_acc),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .stack_push(stack_push), .stack_push_data(stack_push_data),
      .stack_pop(stack_pop), .pc_load(pc_load),
      .pc_load_value(pc_load_value));

   always #12.5 clk = ~clk;

   // ****************************************
   // data memory and pulse recorder
   // ****************************************
   function automatic logic [7:0] pat(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'hA5;
   endfunction : pat

   function automatic logic ind(input logic [11:0] a);
      return (a >= ests_pkg::IND_LO) && (a <= ests_pkg::IND_HI);
   endfunction : ind

   always @(posedge clk) begin
      if (mem_rd === 1'b1) begin
         rd_q.push_back({20'h00000, mem_addr});
         mem_rdata <= pat(mem_addr);
      end else begin
         mem_rdata <= ~mem_rdata;
      end
      if (mem_wr === 1'b1) wr_q.push_back({12'h000, mem_addr, mem_wdata});
      if (stack_push === 1'b1) push_q.push_back({11'h000, stack_push_data});
      if (pc_load === 1'b1) load_q.push_back({11'h000, pc_load_value});
      if (stack_pop === 1'b1) pops++;
   end

   // ****************************************
   // helpers
   // ****************************************
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic cmp_q(input string nm, ref logic [31:0] e[$],
         ref logic [31:0] g[$]);
      chk(nm, e.size(), g.size());
      foreach (e[i]) if (i < g.size()) chk(nm, e[i], g[i]);
      e.delete();
      g.delete();
   endtask : cmp_q

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [15:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk("reg_rdata", {16'h0000, e}, {16'h0000, reg_rdata});
      @(posedge clk);
   endtask : rchk

   task automatic set_fp(input int p, input logic [11:0] v);
      wr(8'h04 + 8'(4 * p), {4'h0, v});
      fp_m[p] = v;
   endtask : set_fp

   task automatic align();
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (cycle_start !== 1'b1 && n < 20);
      if (n >= 20) failures++;
      repeat (4) @(posedge clk);
   endtask : align

   task automatic issue(input logic [15:0] w);
      instr <= w;
      repeat (4) @(posedge clk);
   endtask : issue

   task automatic settle();
      issue(16'h0000);
      issue(16'h0000);
      cmp_q("mem_read", erd, rd_q);
      cmp_q("mem_write", ewr, wr_q);
      cmp_q("stack_push", epush, push_q);
      cmp_q("pc_load", eload, load_q);
      chk("stack_pop", epops, pops);
      epops = 0;
      pops = 0;
   endtask : settle

   task automatic std_loop(input logic ext);
      logic [31:0] r;
      logic [7:0] f;
      logic [11:0] e;
      align();
      for (int i = 0; i < 12; i++) begin
         r = xs();
         f = (r[7:0] >= 8'h60 && r[7:0] < 8'h80) ? r[7:0] - 8'h40 : r[7:0];
         if (r[8]) e = {r[15:12], f};
         else if (ext && f <= 8'h5F) e = fp_m[2] + {4'h0, f};
         else e = {(f >= 8'h80) ? 4'hF : 4'h0, f};
         bank_select <= r[15:12];
         issue({6'b001001, r[9:8], f});
         chk("std_addr", e, std_addr);
         chk("std_dest", !r[9], std_dest_to_acc);
         chk("ext_active", 32'h0, ext_active);
      end
   endtask : std_loop

   task automatic end_sim();
      $display("compared %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      end_sim();
   end

   // ****************************************
   // scenarios
   // ****************************************
   logic [11:0] t_fp[4] = '{12'h080, 12'hFF0, 12'hFD0, 12'hFD0};
   logic [6:0] t_zs[4] = '{7'h05, 7'h20, 7'h10, 7'h05};
   logic [11:0] t_d[4] = '{12'h000, 12'h07F, 12'h005, 12'h015};

   initial begin
      logic [31:0] r;
      logic [11:0] src, dst;
      logic [7:0] dat;
      int p;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rchk(8'h00, 16'h0000);
      for (int i = 0; i < 3; i++) rchk(8'h04 + 8'(4 * i), 16'h0000);
      rchk(8'h20, 16'h0000);
      set_fp(2, 12'h123);
      std_loop(1'b0);
      align();
      issue(16'hFA55);
      settle();
      rchk(8'h0C, 16'h0123);
      wr(8'h00, 16'h0001);
      rchk(8'h00, 16'h0001);
      set_fp(2, 12'h000);
      std_loop(1'b1);
      set_fp(2, xs() & 12'hFFF);
      std_loop(1'b1);
      // back-to-back pushes wrap the frame pointer below zero
      set_fp(2, 12'h001);
      align();
      for (int j = 0; j < 2; j++) begin
         dat = xs();
         issue({8'hFA, dat});
         ewr.push_back({12'h000, fp_m[2], dat});
         fp_m[2] = fp_m[2] - 12'h001;
      end
      settle();
      rchk(8'h0C, {4'h0, fp_m[2]});
      // pointer subtract, select 3 also returns
      for (int f = 0; f < 4; f++) begin
         r = xs();
         p = (f == 3) ? 2 : f;
         set_fp(p, r[27:16]);
         stack_top <= r[20:0];
         align();
         issue({8'hE9, 2'(f), r[5:0]});
         if (f == 3) begin
            eload.push_back({11'h000, r[20:0]});
            epops = 1;
         end
         fp_m[p] = fp_m[p] - {6'h00, r[5:0]};
         settle();
         rchk(8'h04 + 8'(4 * p), {4'h0, fp_m[p]});
      end
      // accumulator-indirect call
      r = xs();
      pc <= {r[20:1], 1'b0};
      acc <= r[31:24];
      pc_high_latch <= r[23:16];
      pc_upper_latch <= r[15:11];
      align();
      issue(ests_pkg::OP_CALL_ACC);
      epush.push_back({11'h000, r[20:1], 1'b0} + 32'h2);
      eload.push_back({11'h000, r[15:11], r[23:16], r[31:24]});
      settle();
      // indexed moves: file, wrap, indirect source, indirect destination
      for (int i = 0; i < 4; i++) begin
         set_fp(2, t_fp[i]);
         src = t_fp[i] + {5'h00, t_zs[i]};
         dst = (i > 0) ? t_fp[i] + {5'h00, t_d[i][6:0]} : t_d[i];
         dat = ind(src) ? 8'h00 : pat(src);
         if (!ind(src)) erd.push_back({20'h00000, src});
         if (!ind(dst)) ewr.push_back({12'h000, dst, dat});
         align();
         issue({ests_pkg::OP_MOVE_FILE | 9'(i > 0), t_zs[i]});
         chk("early_write", 32'h0, wr_q.size());
         chk("ext_active", 32'h1, ext_active);
         issue((i > 0) ? {9'h1E0, t_d[i][6:0]} : {4'hF, t_d[i]});
         issue(16'h0000);
         settle();
      end
      end_sim();
   end
endmodule : tb_extended_stack_instruction_exec

`default_nettype wire
